/* include/wkseq_map.svh */
`ifndef WKSEQ_MAP_SVH
`define WKSEQ_MAP_SVH

// register byte offsets
`define WKSEQ_OFF_CTRL 16'h0000
`define WKSEQ_OFF_STAT 16'h0004
`define WKSEQ_OFF_ISTAT 16'h0008
`define WKSEQ_OFF_IEN 16'h000C
`define WKSEQ_OFF_ICLR 16'h0010
`define WKSEQ_OFF_ALSEL 16'h0014

// ctrl fields
`define WKSEQ_CTRL_QUICK 0
`define WKSEQ_CTRL_AUTOFET 1
`define WKSEQ_CTRL_AUTOREG 2
`define WKSEQ_CTRL_CHG_OFF 3
`define WKSEQ_CTRL_DSG_OFF 4
`define WKSEQ_CTRL_RESET 32'h0000_0000

// event / flag bit positions
`define WKSEQ_EV_REG 0
`define WKSEQ_EV_BOOT_BEGUN 1
`define WKSEQ_EV_BOOT_DONE 2
`define WKSEQ_EV_CONV_PASS 3
`define WKSEQ_EV_FULL_SCAN 4
`define WKSEQ_EV_FET_ON 5
`define WKSEQ_EV_W 6

// timing in milliseconds and microseconds
`define WKSEQ_CLK_HZ 250000000
`define WKSEQ_T_REG_MS 20
`define WKSEQ_T_BOOT_MS 23
`define WKSEQ_T_DONE_SLOW_MS 88
`define WKSEQ_T_DONE_FAST_MS 58
`define WKSEQ_T_FULL_SLOW_MS 221
`define WKSEQ_T_FULL_FAST_MS 129
`define WKSEQ_T_FET_SLOW_MS 282
`define WKSEQ_T_FET_FAST_MS 284
`define WKSEQ_T_TICK_MS 250
`define WKSEQ_T_PULSE_US 150
`define WKSEQ_CYC_PER_MS (`WKSEQ_CLK_HZ / 1000)
`define WKSEQ_CYC_PER_US (`WKSEQ_CLK_HZ / 1000000)

`endif

/* include/wkseq_pkg.sv */
package wkseq_pkg;
    typedef enum logic [2:0] {
        WKSEQ_SHUT = 3'b000,
        WKSEQ_WAIT_REG = 3'b001,
        WKSEQ_WAIT_BOOT = 3'b011,
        WKSEQ_WAIT_DONE = 3'b010,
        WKSEQ_WAIT_FULL = 3'b110,
        WKSEQ_WAIT_FET = 3'b111,
        WKSEQ_NORMAL = 3'b101
    } wkseq_state_type;

    typedef enum logic [1:0] {
        WKSEQ_DG_IDLE = 2'b00,
        WKSEQ_DG_PULSE = 2'b01,
        WKSEQ_DG_HIZ = 2'b11
    } wkseq_dg_type;
endpackage

/* src/wkseq_dsg_drv.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wkseq_map.svh"

module wkseq_dsg_drv
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // control
    input wire logic i_off,
    input wire logic i_above_ld,
    input wire logic i_near_ld,
    // pin drive
    output logic o_pull_low,
    output logic o_hiz,
    output logic o_pulsing
);
    localparam logic [15:0] PULSE_CYC =
        16'(`WKSEQ_T_PULSE_US * `WKSEQ_CYC_PER_US);

    typedef struct packed {
        wkseq_pkg::wkseq_dg_type st;
        logic [15:0] cnt;
        logic pull;
        logic hiz;
    } wkseq_dg_state_type;

    wkseq_dg_state_type s_q;
    wkseq_dg_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            wkseq_pkg::WKSEQ_DG_IDLE:
            begin
                s_d.pull = 1'b0;
                s_d.hiz = 1'b0;
                if (i_off)
                begin
                    s_d.st = wkseq_pkg::WKSEQ_DG_PULSE;
                    s_d.cnt = 16'h0000;
                    s_d.pull = i_above_ld;
                end
            end
            wkseq_pkg::WKSEQ_DG_PULSE:
            begin
                // stop below load level, resume once it relaxes above
                s_d.pull = i_above_ld;
                s_d.cnt = s_q.cnt + 16'h0001;
                if (s_q.cnt == PULSE_CYC - 16'h0001)
                begin
                    s_d.st = wkseq_pkg::WKSEQ_DG_HIZ;
                    s_d.pull = 1'b0;
                    s_d.hiz = 1'b1;
                end
            end
            wkseq_pkg::WKSEQ_DG_HIZ:
            begin
                // hi-z only while close to load level, else pull again if above it
                s_d.hiz = i_near_ld;
                s_d.pull = !i_near_ld && i_above_ld;
            end
            default:
            begin
                s_d.st = wkseq_pkg::WKSEQ_DG_IDLE;
            end
        endcase
        if (!i_off)
        begin
            s_d.st = wkseq_pkg::WKSEQ_DG_IDLE;
            s_d.pull = 1'b0;
            s_d.hiz = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s_q <= '{st: wkseq_pkg::WKSEQ_DG_IDLE, cnt: 16'h0000, pull: 1'b0, hiz: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_pull_low = s_q.pull;
    assign o_hiz = s_q.hiz;
    assign o_pulsing = (s_q.st == wkseq_pkg::WKSEQ_DG_PULSE);
endmodule // wkseq_dsg_drv

`default_nettype wire

/* src/wkseq_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wkseq_map.svh"

// Notes on behaviour
// - thermistor low or load pull-up wakes
// - fet decision only on 250 ms tick
// - aux regulator on at 20 ms
// - boot-begun flag at 23 ms, alertable
// - boot-done and scan-done together, 88/58 ms
// - complete-scan flag at 221/129 ms
// - fets enabled at 282/284 ms
// - charge gate pulled to stack top
// - discharge gate pulled low above load level
// - resume pulling when it relaxes above
// - pulse train ends after about 150 us
// - then hi-z while near load level
// - alert low while selected flag active
module wkseq_top
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // avalon-mm slave
    input wire logic [15:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // wake sources and comparators
    input wire logic i_thermistor_two_pin_low,
    input wire logic i_load_detect_pin_high,
    input wire logic i_dsg_above_ld,
    input wire logic i_dsg_near_ld,
    // pin drives
    output logic o_aux_regulator_one_en,
    output logic o_charge_gate_drive_on,
    output logic o_charge_gate_drive_to_stack_top,
    output logic o_discharge_gate_drive_on,
    output logic o_discharge_gate_drive_pull_low,
    output logic o_discharge_gate_drive_hiz,
    // alert pin, open drain
    output logic o_alert_pin_out,
    output logic o_alert_pin_oe,
    // interrupt
    output logic o_irq
);
    localparam logic [31:0] MS = 32'(`WKSEQ_CYC_PER_MS);

    function automatic logic [31:0] ms_cyc(input logic [31:0] ms);
        ms_cyc = 32'(ms * MS);
    endfunction

    function automatic logic [31:0] flag_word(input logic [5:0] v);
        flag_word = {26'h000_0000, v};
    endfunction

    function automatic logic any_hit(input logic [5:0] a, input logic [5:0] b);
        any_hit = |(a & b);
    endfunction

    typedef struct packed {
        wkseq_pkg::wkseq_state_type st;
        logic [31:0] t;
        logic [31:0] tick;
        logic quick;
        logic autofet;
        logic autoreg;
        logic chg_off;
        logic dsg_off;
        logic [5:0] flags;
        logic [5:0] istat;
        logic [5:0] ien;
        logic [5:0] alsel;
        logic reg_en;
        logic fet_on;
        logic alert;
        logic irq;
        logic chg_gate;
        logic chg_pull;
        logic dsg_gate;
        logic [31:0] rdata;
        logic wait_n;
    } wkseq_state_struct_type;

    logic rst_s1_q;
    logic rst_n_q;
    wkseq_state_struct_type s_q;
    wkseq_state_struct_type s_d;
    logic dg_pull;
    logic dg_hiz;

    // asserts at once, releases two edges later, clear of setup
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // turn-off pulse train runs in its own small machine
    wkseq_dsg_drv u_dsg
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_q),
        .i_off(s_q.dsg_off),
        .i_above_ld(i_dsg_above_ld),
        .i_near_ld(i_dsg_near_ld),
        .o_pull_low(dg_pull),
        .o_hiz(dg_hiz),
        .o_pulsing()
    );

    logic [5:0] ev;
    logic acc;
    logic [31:0] t_done;
    logic [31:0] t_full;
    logic [31:0] t_fet;

    always_comb
    begin
        s_d = s_q;
        ev = 6'h00;
        // quick setting is frozen at wake, so the timeline does not shift mid-run
        if (s_q.quick)
        begin
            t_done = ms_cyc(`WKSEQ_T_DONE_FAST_MS);
            t_full = ms_cyc(`WKSEQ_T_FULL_FAST_MS);
            t_fet = ms_cyc(`WKSEQ_T_FET_FAST_MS);
        end
        else
        begin
            t_done = ms_cyc(`WKSEQ_T_DONE_SLOW_MS);
            t_full = ms_cyc(`WKSEQ_T_FULL_SLOW_MS);
            t_fet = ms_cyc(`WKSEQ_T_FET_SLOW_MS);
        end
        if (s_q.st != wkseq_pkg::WKSEQ_SHUT)
        begin
            s_d.t = s_q.t + 32'h0000_0001;
        end
        case (s_q.st)
            wkseq_pkg::WKSEQ_SHUT:
            begin
                // either wake source leaves shutdown
                s_d.t = 32'h0000_0000;
                if (i_thermistor_two_pin_low || i_load_detect_pin_high)
                begin
                    s_d.st = wkseq_pkg::WKSEQ_WAIT_REG;
                    s_d.t = 32'h0000_0001;
                end
            end
            wkseq_pkg::WKSEQ_WAIT_REG:
            begin
                // milestone flag rises even when the regulator stays off
                if (s_q.t == ms_cyc(`WKSEQ_T_REG_MS))
                begin
                    s_d.reg_en = s_q.autoreg;
                    ev[`WKSEQ_EV_REG] = 1'b1;
                    s_d.st = wkseq_pkg::WKSEQ_WAIT_BOOT;
                end
            end
            wkseq_pkg::WKSEQ_WAIT_BOOT:
            begin
                if (s_q.t == ms_cyc(`WKSEQ_T_BOOT_MS))
                begin
                    ev[`WKSEQ_EV_BOOT_BEGUN] = 1'b1;
                    s_d.st = wkseq_pkg::WKSEQ_WAIT_DONE;
                end
            end
            wkseq_pkg::WKSEQ_WAIT_DONE:
            begin
                if (s_q.t == t_done)
                begin
                    ev[`WKSEQ_EV_BOOT_DONE] = 1'b1;
                    ev[`WKSEQ_EV_CONV_PASS] = 1'b1;
                    s_d.st = wkseq_pkg::WKSEQ_WAIT_FULL;
                end
            end
            wkseq_pkg::WKSEQ_WAIT_FULL:
            begin
                if (s_q.t == t_full)
                begin
                    ev[`WKSEQ_EV_FULL_SCAN] = 1'b1;
                    s_d.st = wkseq_pkg::WKSEQ_WAIT_FET;
                end
            end
            wkseq_pkg::WKSEQ_WAIT_FET:
            begin
                // first evaluation tick lands at the documented fet time
                if (s_q.t == t_fet)
                begin
                    s_d.st = wkseq_pkg::WKSEQ_NORMAL;
                    s_d.tick = 32'h0000_0000;
                    if (s_q.autofet)
                    begin
                        s_d.fet_on = 1'b1;
                        ev[`WKSEQ_EV_FET_ON] = 1'b1;
                    end
                end
            end
            wkseq_pkg::WKSEQ_NORMAL:
            begin
                // enables on a tick when autofet is set, the fets are off and no turn-off is held, after a turn-off or a late autofet set
                s_d.tick = s_q.tick + 32'h0000_0001;
                if (s_q.tick == ms_cyc(`WKSEQ_T_TICK_MS) - 32'h0000_0001)
                begin
                    s_d.tick = 32'h0000_0000;
                    if (s_q.autofet && !s_q.fet_on)
                    begin
                        s_d.fet_on = 1'b1;
                        ev[`WKSEQ_EV_FET_ON] = 1'b1;
                    end
                end
            end
            default:
            begin
                s_d.st = wkseq_pkg::WKSEQ_SHUT;
            end
        endcase
        // flags stay set until reset; only istat can be cleared
        s_d.flags = s_q.flags | ev;

        // register bus
        // one fixed wait cycle lets read data leave a flop
        acc = (i_avs_read || i_avs_write) && s_q.wait_n;
        s_d.wait_n = (i_avs_read || i_avs_write) && !s_q.wait_n;
        s_d.rdata = 32'h0000_0000;
        if (i_avs_write && acc)
        begin
            case (i_avs_address)
                `WKSEQ_OFF_CTRL:
                begin
                    // quick select locked once awake
                    if (s_q.st == wkseq_pkg::WKSEQ_SHUT)
                    begin
                        s_d.quick = i_avs_writedata[`WKSEQ_CTRL_QUICK];
                    end
                    s_d.autofet = i_avs_writedata[`WKSEQ_CTRL_AUTOFET];
                    s_d.autoreg = i_avs_writedata[`WKSEQ_CTRL_AUTOREG];
                    s_d.chg_off = i_avs_writedata[`WKSEQ_CTRL_CHG_OFF];
                    s_d.dsg_off = i_avs_writedata[`WKSEQ_CTRL_DSG_OFF];
                end
                `WKSEQ_OFF_IEN:
                begin
                    s_d.ien = i_avs_writedata[5:0];
                end
                `WKSEQ_OFF_ICLR:
                begin
                    s_d.istat = s_q.istat & ~i_avs_writedata[5:0];
                end
                `WKSEQ_OFF_ALSEL:
                begin
                    s_d.alsel = i_avs_writedata[5:0];
                end
                default:
                begin
                    // unmapped writes are ignored
                    s_d.ien = s_q.ien;
                end
            endcase
        end
        if (i_avs_read && !s_q.wait_n)
        begin
            case (i_avs_address)
                `WKSEQ_OFF_CTRL:
                begin
                    s_d.rdata = {27'h000_0000, s_q.dsg_off, s_q.chg_off,
                        s_q.autoreg, s_q.autofet, s_q.quick};
                end
                `WKSEQ_OFF_STAT:
                begin
                    s_d.rdata = {22'h00_0000, s_q.st, 1'b0, s_q.flags};
                end
                `WKSEQ_OFF_ISTAT:
                begin
                    s_d.rdata = flag_word(s_q.istat);
                end
                `WKSEQ_OFF_IEN:
                begin
                    s_d.rdata = flag_word(s_q.ien);
                end
                `WKSEQ_OFF_ALSEL:
                begin
                    s_d.rdata = flag_word(s_q.alsel);
                end
                default:
                begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        // set wins over a clear in the same cycle
        s_d.istat = s_d.istat | ev;

        // fet turn-off overrides the autonomous enable
        if (s_q.chg_off || s_q.dsg_off)
        begin
            s_d.fet_on = 1'b0;
        end
        s_d.chg_gate = s_q.fet_on && !s_q.chg_off;
        // charge gate held at stack top, switch off, while turn-off is held
        s_d.chg_pull = s_q.chg_off;
        s_d.dsg_gate = s_q.fet_on && !s_q.dsg_off;
        // alert and irq each lag the flags by one cycle
        s_d.alert = any_hit(s_q.flags, s_q.alsel);
        s_d.irq = any_hit(s_q.istat, s_q.ien);
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // readdata valid in the cycle waitrequest drops
    assign o_avs_readdata = s_q.rdata;
    assign o_avs_waitrequest = !s_q.wait_n;
    assign o_aux_regulator_one_en = s_q.reg_en;
    assign o_charge_gate_drive_on = s_q.chg_gate;
    assign o_charge_gate_drive_to_stack_top = s_q.chg_pull;
    assign o_discharge_gate_drive_on = s_q.dsg_gate;
    assign o_discharge_gate_drive_pull_low = dg_pull;
    assign o_discharge_gate_drive_hiz = dg_hiz;
    assign o_alert_pin_out = 1'b0;
    assign o_alert_pin_oe = s_q.alert;
    assign o_irq = s_q.irq;
endmodule // wkseq_top

`default_nettype wire

/* bench/wkseq_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module wkseq_chk
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // bus
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // wake, comparator and pins
    input wire logic i_thermistor_two_pin_low,
    input wire logic i_load_detect_pin_high,
    input wire logic i_dsg_above_ld,
    input wire logic o_aux_regulator_one_en,
    input wire logic o_charge_gate_drive_on,
    input wire logic o_charge_gate_drive_to_stack_top,
    input wire logic o_discharge_gate_drive_on,
    input wire logic o_discharge_gate_drive_pull_low,
    input wire logic o_discharge_gate_drive_hiz,
    input wire logic o_alert_pin_out,
    input wire logic o_alert_pin_oe
);
    // cycles since first wake; saturates so late milestones stay ordered
    logic [31:0] wake_cnt_q;
    logic [31:0] wake_cnt_d;
    always_comb
    begin
        wake_cnt_d = wake_cnt_q;
        if (wake_cnt_q != 32'h0000_0000 && wake_cnt_q != 32'hFFFF_FFFF)
            wake_cnt_d = wake_cnt_q + 32'h0000_0001;
        else if (wake_cnt_q == 32'h0000_0000
            && (i_thermistor_two_pin_low || i_load_detect_pin_high))
            wake_cnt_d = 32'h0000_0001;
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            wake_cnt_q <= 32'h0000_0000;
        else
            wake_cnt_q <= wake_cnt_d;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_ack;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_req |=> s_ack)
        else $error("bus answer not after exactly one wait cycle");
    AST_RDATA_IDLE: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0000_0000)
        else $error("read data not zero outside answer");
    AST_NO_WAKE_OFF: assert property (wake_cnt_q == 32'h0000_0000
        |-> !o_aux_regulator_one_en && !o_discharge_gate_drive_on)
        else $error("output active without wake");
    AST_REG_TIME: assert property ($rose(o_aux_regulator_one_en)
        |-> wake_cnt_q >= 32'h004C_4B36 && wake_cnt_q <= 32'h004C_4B4A)
        else $error("regulator enabled at wrong time");
    AST_FET_LATE: assert property ($rose(o_discharge_gate_drive_on)
        |-> wake_cnt_q >= 32'h0433_BE96)
        else $error("fets enabled too early");
    AST_CHG_OFF: assert property (o_charge_gate_drive_to_stack_top
        |-> !o_charge_gate_drive_on)
        else $error("charge gate on while pulled to stack top");
    AST_PULL_ABOVE: assert property (o_discharge_gate_drive_pull_low
        |-> $past(i_dsg_above_ld) && !o_discharge_gate_drive_on)
        else $error("discharge gate pulled while not above load");
    AST_HIZ_NO_PULL: assert property (o_discharge_gate_drive_hiz
        |-> !o_discharge_gate_drive_pull_low)
        else $error("discharge gate pulled while high impedance");
    AST_ALERT_DRIVE: assert property (o_alert_pin_oe |-> o_alert_pin_out == 1'b0)
        else $error("alert pin driven high");
endmodule // wkseq_chk
bind wkseq_top wkseq_chk u_chk (.i_clk_sys, .i_arst_n, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .i_thermistor_two_pin_low, .i_load_detect_pin_high, .i_dsg_above_ld,
    .o_aux_regulator_one_en, .o_charge_gate_drive_on, .o_charge_gate_drive_to_stack_top,
    .o_discharge_gate_drive_on, .o_discharge_gate_drive_pull_low, .o_discharge_gate_drive_hiz,
    .o_alert_pin_out, .o_alert_pin_oe);
`default_nettype wire

/* bench/wkseq_gate_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wkseq_gate_model
(
    // clock
    input wire logic i_clk_sys,
    // discharge gate and alert pin
    input wire logic i_pull_low,
    input wire logic i_alert_out,
    input wire logic i_alert_oe,
    output logic o_above_ld,
    output logic o_near_ld,
    output logic o_alert_level
);
    // gate in mV relative to load level; relaxes upward so pulling repeats
    int gate_mv = 3000;
    always @(posedge i_clk_sys)
        gate_mv <= i_pull_low ? gate_mv - 40 : (gate_mv < 200 ? gate_mv + 10 : gate_mv);
    assign o_above_ld = gate_mv > 0;
    assign o_near_ld = gate_mv < 500 && gate_mv > -500;
    // pull-up on the open-drain alert line
    assign o_alert_level = i_alert_oe ? i_alert_out : 1'b1;
endmodule // wkseq_gate_model
`default_nettype wire

/* bench/tb_wakeup_sequencer_fet_turnoff.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wkseq_map.svh"
module tb_wakeup_sequencer_fet_turnoff;
    logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, th = 1'b0, ld = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic wreq, above, near, reg_en, chg_on, chg_top, dsg_on, dsg_pull, dsg_hiz;
    logic al_out, al_oe, al_lvl, irq;
    int err_count = 0, comparisons = 0;
    wkseq_top dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_thermistor_two_pin_low(th), .i_load_detect_pin_high(ld),
        .i_dsg_above_ld(above), .i_dsg_near_ld(near), .o_aux_regulator_one_en(reg_en),
        .o_charge_gate_drive_on(chg_on), .o_charge_gate_drive_to_stack_top(chg_top),
        .o_discharge_gate_drive_on(dsg_on), .o_discharge_gate_drive_pull_low(dsg_pull),
        .o_discharge_gate_drive_hiz(dsg_hiz), .o_alert_pin_out(al_out), .o_alert_pin_oe(al_oe),
        .o_irq(irq));
    wkseq_gate_model u_gate (.i_clk_sys(clk), .i_pull_low(dsg_pull), .i_alert_out(al_out),
        .i_alert_oe(al_oe), .o_above_ld(above), .o_near_ld(near), .o_alert_level(al_lvl));
    initial
    begin
        forever #2 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (n >= 50)
            chk("bus_answer", 32'h0000_0000, 32'h0000_0001);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic do_reset;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        do_reset();
        bus(0, `WKSEQ_OFF_CTRL, 32'h0000_0000, r);
        chk("ctrl_rst", r, `WKSEQ_CTRL_RESET);
        bus(0, `WKSEQ_OFF_STAT, 32'h0000_0000, r);
        chk("stat_rst", r, 32'h0000_0000);
        bus(1, 16'h0020, 32'h0000_0001, r);
        bus(0, 16'h0020, 32'h0000_0000, r);
        chk("unmapped", r, 32'h0000_0000);
        bus(1, `WKSEQ_OFF_IEN, 32'h0000_003F, r);
        bus(1, `WKSEQ_OFF_ALSEL, 32'h0000_003F, r);
        bus(1, `WKSEQ_OFF_ICLR, 32'h0000_003F, r);
        bus(0, `WKSEQ_OFF_IEN, 32'h0000_0000, r);
        chk("ien", r, 32'h0000_003F);
        bus(0, `WKSEQ_OFF_ALSEL, 32'h0000_0000, r);
        chk("alsel", r, 32'h0000_003F);
        bus(0, `WKSEQ_OFF_ISTAT, 32'h0000_0000, r);
        chk("istat", r, 32'h0000_0000);
        bus(0, `WKSEQ_OFF_CTRL, 32'h0000_0000, r);
        chk("ctrl_kept", r, `WKSEQ_CTRL_RESET);
        @(negedge clk);
        chk("irq_idle", irq, 1'b0);
        chk("alert_idle", al_lvl, 1'b1);
    endtask
    // wake from either source; quick select locked once awake
    task automatic t_wake(input int src);
        logic [31:0] r;
        do_reset();
        bus(1, `WKSEQ_OFF_CTRL, src == 0 ? 32'h0000_0007 : 32'h0000_0006, r);
        @(posedge clk);
        if (src == 0)
            th <= 1'b1;
        else
            ld <= 1'b1;
        repeat (4) @(posedge clk);
        th <= 1'b0;
        ld <= 1'b0;
        bus(0, `WKSEQ_OFF_STAT, 32'h0000_0000, r);
        chk("stat_wake", r, 32'h0000_0080);
        bus(1, `WKSEQ_OFF_CTRL, src == 0 ? 32'h0000_0006 : 32'h0000_0007, r);
        bus(0, `WKSEQ_OFF_CTRL, 32'h0000_0000, r);
        chk("quick_locked", r, src == 0 ? 32'h0000_0007 : 32'h0000_0006);
        repeat (2000) @(negedge clk);
        chk("reg_early", reg_en, 1'b0);
        chk("fet_early", dsg_on, 1'b0);
    endtask
    task automatic t_drivers;
        logic [31:0] r;
        logic prev;
        int n;
        int pulses;
        n = 0;
        pulses = 0;
        prev = 1'b0;
        do_reset();
        bus(1, `WKSEQ_OFF_CTRL, 32'h0000_0018, r);
        repeat (3) @(negedge clk);
        chk("chg_top", chg_top, 1'b1);
        chk("chg_on", chg_on, 1'b0);
        while (dsg_hiz !== 1'b1 && n < 40000)
        begin
            @(negedge clk);
            n++;
            if (dsg_pull === 1'b1 && !prev)
                pulses++;
            prev = dsg_pull;
        end
        chk("pulse_len", n >= 37480 && n <= 37510, 1'b1);
        chk("pulse_train", pulses > 2, 1'b1);
        repeat (100) @(negedge clk);
        chk("hiz", dsg_hiz, 1'b1);
        chk("pull_after", dsg_pull, 1'b0);
        chk("dsg_on", dsg_on, 1'b0);
    endtask
    initial
    begin
        t_regs();
        t_wake(0);
        t_wake(1);
        t_drivers();
        tally_and_finish();
    end
    // run needs about 42k cycles
    initial
    begin
        #400_000;
        err_count++;
        tally_and_finish();
    end
endmodule // tb_wakeup_sequencer_fet_turnoff
`default_nettype wire
